// ===== src/pic_priority_ctrl.sv
// Purpose: prioritised interrupt and trap controller with APB register access
// Assumes: peripheral requests and trap events are one-cycle pulses on pclk
// Notes: external interrupt pins are synchronised and edge detected here
//
// The APB register port and the register offsets were decided locally.
`include "pic_consts.svh"
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - twenty-eight controller registers on the bus
// - request flag sticky until software clears it
// - disabled source never gets presented
// - three-bit priority per source, eight levels
// - pending status holds vector and level
// - pending level equals source programmed priority
// - bit positions follow vector order
// - status word bits 7:5 hold level
// - top level bit never settable by software
// - level seven blocks all user interrupts
// - top bit set blocks user interrupts
// - nesting off makes level bits read-only
// - control one bit 15 disables nesting
// - bits 14,13 flag accumulator overflow traps
// - bits 12,11 flag catastrophic overflow traps
// - bits 10,9,8 enable overflow traps
// - bits 7,6 record math trap cause
// - bit 4 records any math trap
// - control two holds edge and table
// - bits 3,2,1 flag address/stack/oscillator traps
// - control two bit 15 selects alternate table
// - control two bits 2:0 select edge polarity
module pic_priority_ctrl #(
    parameter int NSRC = 60
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NSRC-1:0] src_req,
    input wire logic [2:0] ext_irq_pin,
    input wire pic_pkg::pic_trap_evt_s trap_evt,
    input wire logic disi_active,
    input wire logic core_level_load,
    input wire pic_pkg::pic_level_t core_level_value,
    output pic_pkg::pic_pend_s pend,
    output pic_pkg::pic_level_t cpu_level,
    output logic nesting_off,
    output logic alt_table_sel,
    output logic trap_pending
);
    import pic_pkg::*;

    localparam int FLAG_BITS = 16 * `PIC_NUM_FLAG_REGS;
    localparam logic [FLAG_BITS-1:0] SRC_MASK = {FLAG_BITS{1'b1}} >> (FLAG_BITS - NSRC);

    // -------------------------------------------------------------------------
    // state
    // -------------------------------------------------------------------------
    logic [15:0] con1;
    logic [15:0] con2;
    logic [FLAG_BITS-1:0] flags;
    logic [FLAG_BITS-1:0] enables;
    logic [2:0] prio [NSRC];
    logic [2:0] cpu_ipl;
    logic cpu_top;
    logic [5:0] pend_idx;
    logic [2:0] ext_s1;
    logic [2:0] ext_s2;
    logic [2:0] ext_s3;
    logic err_q;

    logic [6:0] idx;
    logic mapped;
    logic wr;
    logic [15:0] rd_val;
    logic [15:0] next_con1;
    logic [FLAG_BITS-1:0] next_flags;
    logic [FLAG_BITS-1:0] hw_set;
    logic [2:0] ext_edge;
    logic [NSRC-1:0] elig;
    logic best_found;
    logic [2:0] best_prio;
    logic [5:0] best_idx;

    assign idx = paddr[8:2];
    assign mapped = (paddr[11:9] == 3'h0) && (paddr[1:0] == 2'h0) && (idx <= `PIC_IDX_CORE);
    assign wr = psel && penable && pwrite && ce && mapped;
    assign pready = ce;
    assign pslverr = psel && penable && err_q;

    assign cpu_level = {cpu_top, cpu_ipl};
    assign nesting_off = con1[`PIC_B_NEST_OFF];
    assign alt_table_sel = con2[`PIC_B_ALT_TABLE];
    assign trap_pending = |(con1 & `PIC_TRAP_FLAGS);

    // -------------------------------------------------------------------------
    // apb read path: data captured in the setup cycle, zero-wait access
    // -------------------------------------------------------------------------
    always_comb begin
        rd_val = 16'h0000;
        if (idx == `PIC_IDX_CON1) begin
            rd_val = con1;
        end else if (idx == `PIC_IDX_CON2) begin
            rd_val = (con2 & `PIC_CON2_WMASK) | (16'(disi_active) << `PIC_B_DISI);
        end else if (idx >= `PIC_IDX_FLAG0 && idx < `PIC_IDX_EN0) begin
            rd_val = flags[(idx - `PIC_IDX_FLAG0) * 16 +: 16];
        end else if (idx >= `PIC_IDX_EN0 && idx < `PIC_IDX_PRIO0) begin
            rd_val = enables[(idx - `PIC_IDX_EN0) * 16 +: 16];
        end else if (idx >= `PIC_IDX_PRIO0 && idx < `PIC_IDX_PEND) begin
            for (int i = 0; i < NSRC; i++) begin
                if (7'(i / 4) == idx - `PIC_IDX_PRIO0) begin
                    rd_val[(i % 4) * 4 +: 3] = prio[i];
                end
            end
        end else if (idx == `PIC_IDX_PEND) begin
            rd_val = {4'h0, pend.level, 1'b0, pend.vector};
        end else if (idx == `PIC_IDX_SR) begin
            rd_val = 16'(cpu_ipl) << `PIC_B_IPL_LSB;
        end else if (idx == `PIC_IDX_CORE) begin
            rd_val = 16'(cpu_top) << `PIC_B_TOP;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            err_q <= 1'b0;
        end else if (ce && psel && !penable) begin
            prdata <= {16'h0000, rd_val};
            err_q <= !mapped;
        end
    end

    // -------------------------------------------------------------------------
    // external interrupt pins: synchroniser and edge select
    // -------------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_s1 <= 3'h0;
            ext_s2 <= 3'h0;
            ext_s3 <= 3'h0;
        end else if (ce) begin
            ext_s1 <= ext_irq_pin;
            ext_s2 <= ext_s1;
            ext_s3 <= ext_s2;
        end
    end

    // polarity bit 1 picks the falling edge
    assign ext_edge = (con2[2:0] & ext_s3 & ~ext_s2) | (~con2[2:0] & ~ext_s3 & ext_s2);

    // -------------------------------------------------------------------------
    // request flags and enables
    // -------------------------------------------------------------------------
    always_comb begin
        hw_set = FLAG_BITS'(src_req);
        hw_set[`PIC_EXT0_SRC] = hw_set[`PIC_EXT0_SRC] | ext_edge[0];
        hw_set[`PIC_EXT1_SRC] = hw_set[`PIC_EXT1_SRC] | ext_edge[1];
        hw_set[`PIC_EXT2_SRC] = hw_set[`PIC_EXT2_SRC] | ext_edge[2];
    end

    always_comb begin
        next_flags = flags;
        for (int r = 0; r < `PIC_NUM_FLAG_REGS; r++) begin
            if (wr && idx == `PIC_IDX_FLAG0 + 7'(r)) begin
                next_flags[r * 16 +: 16] = pwdata[15:0];
            end
        end
        // a request in the clearing cycle still lands
        next_flags = (next_flags | hw_set) & SRC_MASK;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags <= '0;
        end else if (ce) begin
            flags <= next_flags;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enables <= '0;
        end else if (ce) begin
            for (int r = 0; r < `PIC_NUM_FLAG_REGS; r++) begin
                if (wr && idx == `PIC_IDX_EN0 + 7'(r)) begin
                    enables[r * 16 +: 16] <= pwdata[15:0] & SRC_MASK[r * 16 +: 16];
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NSRC; i++) begin
                prio[i] <= 3'h0;
            end
        end else if (ce) begin
            for (int i = 0; i < NSRC; i++) begin
                if (wr && idx == `PIC_IDX_PRIO0 + 7'(i / 4)) begin
                    prio[i] <= pwdata[(i % 4) * 4 +: 3];
                end
            end
        end
    end

    // -------------------------------------------------------------------------
    // global control registers
    // -------------------------------------------------------------------------
    always_comb begin
        next_con1 = con1;
        if (wr && idx == `PIC_IDX_CON1) begin
            next_con1 = pwdata[15:0] & `PIC_CON1_MASK;
        end
        if (trap_evt.acc_a_ovf && con1[`PIC_B_OVA_EN]) begin
            next_con1[`PIC_B_OVA_FLAG] = 1'b1;
        end
        if (trap_evt.acc_b_ovf && con1[`PIC_B_OVB_EN]) begin
            next_con1[`PIC_B_OVB_FLAG] = 1'b1;
        end
        if (trap_evt.acc_a_cat && con1[`PIC_B_COV_EN]) begin
            next_con1[`PIC_B_COVA_FLAG] = 1'b1;
        end
        if (trap_evt.acc_b_cat && con1[`PIC_B_COV_EN]) begin
            next_con1[`PIC_B_COVB_FLAG] = 1'b1;
        end
        if (trap_evt.bad_shift) begin
            next_con1[`PIC_B_SHIFT] = 1'b1;
        end
        if (trap_evt.div_zero) begin
            next_con1[`PIC_B_DIV0] = 1'b1;
        end
        if (trap_evt.bad_shift || trap_evt.div_zero) begin
            next_con1[`PIC_B_MATH] = 1'b1;
        end
        if (trap_evt.addr_err) begin
            next_con1[`PIC_B_ADDR] = 1'b1;
        end
        if (trap_evt.stack_err) begin
            next_con1[`PIC_B_STACK] = 1'b1;
        end
        if (trap_evt.osc_fail) begin
            next_con1[`PIC_B_OSC] = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            con1 <= `PIC_RST_WORD;
        end else if (ce) begin
            con1 <= next_con1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            con2 <= `PIC_RST_WORD;
        end else if (ce && wr && idx == `PIC_IDX_CON2) begin
            con2 <= pwdata[15:0] & `PIC_CON2_WMASK;
        end
    end

    // -------------------------------------------------------------------------
    // cpu priority level: core loads it, software may lower or change it
    // -------------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_ipl <= 3'h0;
        end else if (ce) begin
            if (core_level_load) begin
                cpu_ipl <= core_level_value[2:0];
            end else if (wr && idx == `PIC_IDX_SR && !nesting_off) begin
                cpu_ipl <= pwdata[`PIC_B_IPL_LSB +: 3];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_top <= 1'b0;
        end else if (ce) begin
            if (core_level_load) begin
                cpu_top <= core_level_value[3];
            end else if (wr && idx == `PIC_IDX_CORE && !pwdata[`PIC_B_TOP]) begin
                cpu_top <= 1'b0;
            end
        end
    end

    // -------------------------------------------------------------------------
    // arbitration and pending status
    // -------------------------------------------------------------------------
    always_comb begin
        best_found = 1'b0;
        best_prio = 3'h0;
        best_idx = 6'h00;
        for (int i = 0; i < NSRC; i++) begin
            // priorities only reach 7, so level 7 and above admit nothing
            elig[i] = flags[i] && enables[i] && ({1'b0, prio[i]} > cpu_level);
            if (elig[i] && (!best_found || prio[i] > best_prio)) begin
                best_found = 1'b1;
                best_prio = prio[i];
                best_idx = 6'(i);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend <= '0;
            pend_idx <= 6'h00;
        end else if (ce) begin
            pend.valid <= best_found;
            if (best_found) begin
                pend.vector <= 7'(best_idx) + `PIC_VEC_BASE;
                pend.level <= {1'b0, best_prio};
                pend_idx <= best_idx;
            end
        end
    end

    // -------------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------------
    logic [FLAG_BITS-1:0] en_d;
    logic [3*NSRC-1:0] prio_d;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_d <= '0;
            prio_d <= '0;
        end else if (ce) begin
            en_d <= enables;
            for (int i = 0; i < NSRC; i++) begin
                prio_d[i * 3 +: 3] <= prio[i];
            end
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_math_event;
        ce && trap_evt.bad_shift;
    endsequence
    sequence s_math_recorded;
        con1[`PIC_B_SHIFT] && con1[`PIC_B_MATH];
    endsequence

    AST_FLAG_STICKY: assert property (
        ce && flags[1] && !(wr && idx == `PIC_IDX_FLAG0) |=> flags[1])
        else $error("request flag dropped without a software write");
    AST_DISABLED_QUIET: assert property (
        pend.valid && $past(ce) |-> en_d[pend_idx])
        else $error("disabled source presented");
    AST_LEVEL_MATCH: assert property (
        pend.valid && $past(ce) |-> pend.level == {1'b0, prio_d[pend_idx * 3 +: 3]})
        else $error("pending level differs from source priority");
    AST_VEC_NUMBER: assert property (
        pend.valid |-> pend.vector == 7'(pend_idx) + `PIC_VEC_BASE)
        else $error("pending vector does not match source position");
    AST_LEVEL7: assert property (
        ce && cpu_ipl == 3'h7 |=> !pend.valid)
        else $error("user interrupt presented at level 7");
    AST_TOP_BLOCKS: assert property (
        ce && cpu_top |=> !pend.valid)
        else $error("user interrupt presented with top level bit set");
    AST_NEST_RO: assert property (
        ce && nesting_off && wr && idx == `PIC_IDX_SR && !core_level_load
        |=> $stable(cpu_ipl))
        else $error("level bits written while nesting is off");
    AST_TOP_NOT_SET: assert property (
        ce && !cpu_top && !core_level_load |=> !cpu_top)
        else $error("software set the top level bit");
    AST_MATH_CAUSE: assert property (
        s_math_event |=> s_math_recorded)
        else $error("math trap cause not recorded");
    AST_OVA_GATED: assert property (
        ce && !con1[`PIC_B_OVA_FLAG] && !con1[`PIC_B_OVA_EN] && !wr
        |=> !con1[`PIC_B_OVA_FLAG])
        else $error("overflow flag set while its trap is disabled");
    AST_UNMAPPED: assert property (
        psel && penable && $past(psel && !penable && ce) && !mapped |-> pslverr)
        else $error("unmapped access not flagged");
endmodule

`default_nettype wire

// ===== src/pic_consts.svh
// Purpose: offsets, field positions and reset values of the interrupt controller
// Assumes: word register index = paddr[8:2]
// Notes: included by its bare name
`ifndef PIC_CONSTS_SVH
`define PIC_CONSTS_SVH

// -----------------------------------------------------------------------------
// register indices (byte address = 4 * index)
// -----------------------------------------------------------------------------
`define PIC_IDX_CON1 7'h00
`define PIC_IDX_CON2 7'h01
`define PIC_IDX_FLAG0 7'h02
`define PIC_IDX_EN0 7'h06
`define PIC_IDX_PRIO0 7'h0A
`define PIC_IDX_PEND 7'h19
`define PIC_IDX_SR 7'h1A
`define PIC_IDX_CORE 7'h1B
`define PIC_NUM_FLAG_REGS 4
`define PIC_NUM_PRIO_REGS 15

// -----------------------------------------------------------------------------
// interrupt control one fields
// -----------------------------------------------------------------------------
`define PIC_B_NEST_OFF 15
`define PIC_B_OVA_FLAG 14
`define PIC_B_OVB_FLAG 13
`define PIC_B_COVA_FLAG 12
`define PIC_B_COVB_FLAG 11
`define PIC_B_OVA_EN 10
`define PIC_B_OVB_EN 9
`define PIC_B_COV_EN 8
`define PIC_B_SHIFT 7
`define PIC_B_DIV0 6
`define PIC_B_MATH 4
`define PIC_B_ADDR 3
`define PIC_B_STACK 2
`define PIC_B_OSC 1
`define PIC_CON1_MASK 16'hFFDE
`define PIC_TRAP_FLAGS 16'h78DE

// -----------------------------------------------------------------------------
// interrupt control two, status words, pending status
// -----------------------------------------------------------------------------
`define PIC_B_ALT_TABLE 15
`define PIC_B_DISI 14
`define PIC_CON2_WMASK 16'h8007
`define PIC_B_IPL_LSB 5
`define PIC_B_TOP 3
`define PIC_B_PEND_LVL_LSB 8
`define PIC_VEC_BASE 7'h08
`define PIC_EXT0_SRC 0
`define PIC_EXT1_SRC 20
`define PIC_EXT2_SRC 29
`define PIC_RST_WORD 16'h0000

`endif

// ===== src/pic_pkg.sv
// Purpose: shared types of the interrupt controller
// Assumes: nothing
// Notes: constants live in pic_consts.svh
package pic_pkg;
    typedef logic [3:0] pic_level_t;

    typedef struct packed {
        logic acc_a_ovf;
        logic acc_b_ovf;
        logic acc_a_cat;
        logic acc_b_cat;
        logic bad_shift;
        logic div_zero;
        logic addr_err;
        logic stack_err;
        logic osc_fail;
    } pic_trap_evt_s;

    typedef struct packed {
        logic valid;
        logic [6:0] vector;
        pic_level_t level;
    } pic_pend_s;
endpackage

// ===== verif/pic_core_model.sv
// Purpose: core and peripheral side that raises requests, traps and level loads
// Assumes: pclk is the controller clock
// Notes: every pulse lasts one cycle and changes just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module pic_core_model (
    input wire logic pclk,
    output var logic [59:0] src_req,
    output var logic [2:0] ext_irq_pin,
    output var pic_pkg::pic_trap_evt_s trap_evt,
    output var logic core_level_load,
    output var pic_pkg::pic_level_t core_level_value
);
    import pic_pkg::*;

    initial begin
        src_req = '0;
        ext_irq_pin = '0;
        trap_evt = '0;
        core_level_load = 1'b0;
        core_level_value = '0;
    end

    task automatic req(input int i);
        @(posedge pclk);
        src_req[i] <= 1'b1;
        @(posedge pclk);
        src_req <= '0;
    endtask

    task automatic trap(input pic_trap_evt_s e);
        @(posedge pclk);
        trap_evt <= e;
        @(posedge pclk);
        trap_evt <= '0;
    endtask

    // core forces the whole level, top bit included
    task automatic load(input pic_level_t v);
        @(posedge pclk);
        core_level_load <= 1'b1;
        core_level_value <= v;
        @(posedge pclk);
        core_level_load <= 1'b0;
        core_level_value <= ~v;
    endtask

    task automatic pins(input logic [2:0] v);
        @(posedge pclk);
        ext_irq_pin <= v;
    endtask
endmodule
`default_nettype wire

// ===== verif/priority_interrupt_controller_test.sv
// Purpose: self-checking bench of the priority interrupt controller
// Assumes: ce high during bus transfers, so each access ends in its first access cycle
// Notes: random priorities, flags and enables from a fixed seed
`include "pic_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module priority_interrupt_controller_test;
    import pic_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic nesting_off, alt_table_sel, trap_pending, core_level_load;
    logic ce, disi_active;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [59:0] src_req;
    logic [2:0] ext_irq_pin;
    pic_trap_evt_s trap_evt;
    pic_level_t core_level_value, cpu_level;
    pic_pend_s pend;
    int err_total, n_compared, seed;
    int cyc = 0;
    logic [15:0] fl, en, exp_w;
    logic [2:0] lvl;
    logic [2:0] pr [16];
    logic [11:0] best;
    logic [11:0] ta [6] = '{12'h068, 12'h06C, 12'h004, 12'h014, 12'h000, 12'h070};
    logic [15:0] tx [6] = '{16'h00E0, 16'h0000, 16'h8007, 16'h0FFF, 16'hFFDE, 16'h0000};
    logic [15:0] tap [9] = '{16'h4000, 16'h2000, 16'h1000, 16'h0800, 16'h0090,
                             16'h0050, 16'h0008, 16'h0004, 16'h0002};

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    pic_priority_ctrl u_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .src_req(src_req),
        .ext_irq_pin(ext_irq_pin), .trap_evt(trap_evt), .disi_active(disi_active),
        .core_level_load(core_level_load), .core_level_value(core_level_value),
        .pend(pend), .cpu_level(cpu_level), .nesting_off(nesting_off),
        .alt_table_sel(alt_table_sel), .trap_pending(trap_pending));

    pic_core_model u_core (.pclk(pclk), .src_req(src_req), .ext_irq_pin(ext_irq_pin),
        .trap_evt(trap_evt), .core_level_load(core_level_load),
        .core_level_value(core_level_value));

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, '0);
        chk(rd, e);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask

    // winner among sources 0..15: {valid, vector, level}
    function automatic logic [11:0] arb();
        logic [3:0] bp;
        logic [11:0] r;
        bp = {1'b0, lvl};
        r = '0;
        for (int i = 0; i < 16; i++) begin
            if (fl[i] && en[i] && {1'b0, pr[i]} > bp) begin
                bp = {1'b0, pr[i]};
                r = {1'b1, 7'(8 + i), bp};
            end
        end
        return r;
    endfunction

    task automatic summarize();
        if (err_total == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            summarize();
        end
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        seed = 20;
        err_total = 0;
        n_compared = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        ce = 1'b1;
        disi_active = 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 29; i++) begin
            apb(1'b0, 12'(4 * i), '0);
            chk({15'h0, rd[15:0], er}, {31'h0, 1'(i == 28)});
        end
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, ta[i], 32'hFFFF_FFFF);
            rdchk(ta[i], {16'h0, tx[i]});
            if (i == 2) begin
                chk(alt_table_sel, 1'b1);
            end
            apb(1'b1, ta[i], '0);
        end
        for (int it = 0; it < 12; it++) begin
            fl = 16'($random(seed));
            en = 16'($random(seed));
            lvl = 3'($random(seed));
            if (it == 0) begin
                lvl = 3'h7;
            end
            if (it == 1) begin
                lvl = 3'h0;
                fl = 16'hFFFF;
                en = 16'hFFFF;
            end
            for (int s = 0; s < 16; s++) begin
                pr[s] = (it == 1) ? 3'h5 : 3'($random(seed));
            end
            for (int r = 0; r < 4; r++) begin
                apb(1'b1, 12'h028 + 12'(4 * r), {16'h0, 1'b0, pr[4*r+3], 1'b0, pr[4*r+2],
                    1'b0, pr[4*r+1], 1'b0, pr[4*r]});
            end
            apb(1'b1, 12'h008, {16'h0, fl});
            apb(1'b1, 12'h018, {16'h0, en});
            apb(1'b1, 12'h068, {24'h0, lvl, 5'h0});
            settle(3);
            best = arb();
            chk(pend.valid, best[11]);
            if (best[11]) begin
                chk({20'h0, pend}, {20'h0, best});
                rdchk(12'h064, {20'h0, best[3:0], 1'b0, best[10:4]});
            end
        end
        apb(1'b1, 12'h008, '0);
        apb(1'b1, 12'h018, '0);
        apb(1'b1, 12'h068, '0);
        u_core.req(5);
        settle(10);
        rdchk(12'h008, 32'h20);
        u_core.req(59);
        rdchk(12'h014, 32'h0800);
        apb(1'b1, 12'h008, '0);
        rdchk(12'h008, '0);
        apb(1'b1, 12'h018, 32'h1);
        apb(1'b1, 12'h028, 32'h7);
        apb(1'b1, 12'h008, 32'h1);
        apb(1'b1, 12'h06C, 32'h8);
        settle(2);
        chk(cpu_level, 4'h0);
        u_core.load(4'h8);
        settle(3);
        chk(pend.valid, 1'b0);
        apb(1'b1, 12'h06C, '0);
        settle(3);
        chk(pend.valid, 1'b1);
        apb(1'b1, 12'h000, 32'h8000);
        settle(1);
        chk(nesting_off, 1'b1);
        apb(1'b1, 12'h068, 32'hA0);
        settle(2);
        chk(cpu_level, 4'h0);
        apb(1'b1, 12'h000, '0);
        apb(1'b1, 12'h068, 32'hA0);
        settle(2);
        chk(cpu_level, 4'h5);
        apb(1'b1, 12'h068, '0);
        apb(1'b1, 12'h008, '0);
        u_core.trap(pic_trap_evt_s'(9'h100));
        rdchk(12'h000, '0);
        apb(1'b1, 12'h000, 32'h0700);
        settle(1);
        chk(trap_pending, 1'b0);
        exp_w = 16'h0700;
        for (int i = 0; i < 9; i++) begin
            u_core.trap(pic_trap_evt_s'(9'h100 >> i));
            exp_w = exp_w | tap[i];
            rdchk(12'h000, {16'h0, exp_w});
        end
        chk(trap_pending, 1'b1);
        apb(1'b1, 12'h000, '0);
        u_core.pins(3'b001);
        settle(6);
        rdchk(12'h008, 32'h1);
        apb(1'b1, 12'h008, '0);
        apb(1'b1, 12'h004, 32'h1);
        u_core.pins(3'b000);
        settle(6);
        rdchk(12'h008, 32'h1);
        apb(1'b1, 12'h008, '0);
        u_core.pins(3'b001);
        settle(6);
        rdchk(12'h008, '0);
        // clock enable low: no answer on the bus and requests are not latched
        disi_active <= 1'b1;
        ce <= 1'b0;
        u_core.req(7);
        chk(pready, 1'b0);
        ce <= 1'b1;
        rdchk(12'h004, 32'h4001);
        rdchk(12'h008, '0);
        summarize();
    end
endmodule
`default_nettype wire
